//--- rtl/ppf_formatter.sv
// Top of the pressure process image formatter with APB registers
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module ppf_formatter
    import ppf_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic CLK,
    input wire logic RST_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Fieldbus cyclic exchange
    input wire logic BUS_CYCLE_ACTIVE,
    input wire logic [47:0] OUTPUT_IMAGE,
    output logic [47:0] INPUT_IMAGE,
    output logic [2:0] IMAGE_BYTES,
    // Conversion results
    input wire logic [1:0] SAMPLE_VALID,
    input wire logic [31:0] SAMPLE_DATA,
    input wire logic [1:0] SAMPLE_ERR,
    output logic IRQ
);
    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:0] ctrl_q, ctrl_d;
    logic [31:0] lim1_q, lim1_d;
    logic [31:0] lim2_q, lim2_d;
    logic [EV_W-1:0] irq_stat_q, irq_stat_d;
    logic [EV_W-1:0] irq_mask_q, irq_mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    ppf_apb_state_t st_q, st_d;
    logic [EV_W-1:0] events;
    logic access;
    logic two_ch;
    logic [7:0] st_oct [2];
    logic [15:0] in_word [2];
    logic [1:0] new_s, rng_s;

    assign two_ch = (NUM_CH > 1) && ctrl_q[CTRL_TWO_CH];

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ch
        ppf_chan_if cif ();
        assign cif.variant = ctrl_q[CTRL_VAR_LO +: 2];
        assign cif.lim1_en = ctrl_q[CTRL_LIM1_EN];
        assign cif.lim2_en = ctrl_q[CTRL_LIM2_EN];
        assign cif.lim1 = lim1_q[i*DATA_W +: DATA_W];
        assign cif.lim2 = lim2_q[i*DATA_W +: DATA_W];
        // Control byte of channel i sits at output image byte 3*i; its word is ignored
        assign cif.ctrl_octet = OUTPUT_IMAGE[i*IMG_BYTES_1CH*BYTE_W +: BYTE_W];
        assign cif.sample_valid = SAMPLE_VALID[i] & ((i == 0) | two_ch);
        assign cif.sample = SAMPLE_DATA[i*DATA_W +: DATA_W];
        assign cif.sample_err = SAMPLE_ERR[i];
        assign st_oct[i] = cif.status_octet;
        assign in_word[i] = cif.input_word;
        assign new_s[i] = cif.new_sample;
        assign rng_s[i] = cif.range_event;
        ppf_channel u_ch (
            .clk(CLK),
            .rst_n(RST_N),
            .ch(cif.chan)
        );
    end

    // ----------------------------------------------------------------
    // Image assembly
    // ----------------------------------------------------------------
    always_comb begin
        // Byte order: status, word low, word high per channel
        INPUT_IMAGE = {24'h000000, in_word[0][15:8], in_word[0][7:0], st_oct[0]};
        IMAGE_BYTES = 3'(IMG_BYTES_1CH);
        if (two_ch) begin
            INPUT_IMAGE = {in_word[1], st_oct[1], in_word[0], st_oct[0]};
            IMAGE_BYTES = 3'(IMG_BYTES_2CH);
        end
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign access = PSEL & PENABLE & (st_q == ST_ACCESS);
    assign events = {rng_s[1], new_s[1], rng_s[0], new_s[0]};

    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (PSEL && !PENABLE) begin
                    st_d = ST_SETUP;
                end
            end
            ST_SETUP: begin
                st_d = ST_ACCESS;
            end
            ST_ACCESS: begin
                // Bus cycle traffic holds the configuration access off
                if (!BUS_CYCLE_ACTIVE) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    assign PREADY = (st_q == ST_ACCESS) & ~BUS_CYCLE_ACTIVE;
    assign PRDATA = rdata_q;
    assign PSLVERR = err_q & PREADY;

    always_comb begin
        ctrl_d = ctrl_q;
        lim1_d = lim1_q;
        lim2_d = lim2_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (st_q == ST_SETUP || (st_q == ST_ACCESS && BUS_CYCLE_ACTIVE)) begin
            rdata_d = ZERO32;
            err_d = 1'b0;
            case (PADDR)
                REG_CTRL: rdata_d = ctrl_q;
                REG_LIM1: rdata_d = lim1_q;
                REG_LIM2: rdata_d = lim2_q;
                REG_STAT: rdata_d = {16'h0000, st_oct[1], st_oct[0]};
                REG_IRQ_STAT: rdata_d = {28'h0000000, irq_stat_q};
                REG_IRQ_MASK: rdata_d = {28'h0000000, irq_mask_q};
                REG_VALUE: rdata_d = {in_word[1], in_word[0]};
                default: err_d = 1'b1;
            endcase
        end else begin
            err_d = err_q & (st_q == ST_ACCESS) & ~PREADY;
        end
        if (access && PREADY && PWRITE) begin
            case (PADDR)
                REG_CTRL: ctrl_d = PWDATA;
                REG_LIM1: lim1_d = PWDATA;
                REG_LIM2: lim2_d = PWDATA;
                REG_IRQ_MASK: irq_mask_d = PWDATA[EV_W-1:0];
                default: ctrl_d = ctrl_q;
            endcase
        end
        // Read clears status; a new event in the same cycle wins
        if (access && PREADY && !PWRITE && PADDR == REG_IRQ_STAT) begin
            irq_stat_d = '0;
        end
        irq_stat_d = irq_stat_d | events;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_q <= ST_IDLE;
            ctrl_q <= CTRL_RST;
            lim1_q <= ZERO32;
            lim2_q <= ZERO32;
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            rdata_q <= ZERO32;
            err_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ctrl_q <= ctrl_d;
            lim1_q <= lim1_d;
            lim2_q <= lim2_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    assign IRQ = |(irq_stat_q & irq_mask_q);
endmodule : ppf_formatter

//--- rtl/ppf_pkg.sv
// Constants, register map and types of the process image formatter
//
// Contract
// - The single-channel variant uses at most three input and three output bytes of image.
// - Each channel has a status byte then a 16-bit input word, and a control byte then a 16-bit output word.
// - In process data mode one channel places its measured value in the input word and ignores the output word.
// - The differential variant reports signed 0.1 hPa counts, +-100 hPa as FC18/03E8, wide +340 hPa as 0D48.
// - The two-channel variants use at most six input and six output bytes of image.
// - Two-channel input order is status one, word one, status two, word two; output mirrors it.
// - In process data mode two channels deliver their values in their input words and use no output word.
// - Relative variants report 1 hPa counts, 0 to 7500 as 1D4C, or +-1000 as FC18/03E8.
// - Cyclic fieldbus traffic takes precedence over configuration accesses.
// - Status bytes travel from the device in the input image, control bytes arrive in the output image.
// - Control bit 7 cleared selects process data mode and status bit 7 cleared acknowledges it.
// - Status bit 6 flags an invalid value, bit 1 over-range, bit 0 under-range.
// - Limit state fields encode 00 disabled, 01 above, 10 below, 11 equal.
package ppf_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    // Variant selection
    localparam logic [1:0] VAR_DIFF = 2'h0;
    localparam logic [1:0] VAR_DIFF_WIDE = 2'h1;
    localparam logic [1:0] VAR_REL_POS = 2'h2;
    localparam logic [1:0] VAR_REL_BIP = 2'h3;
    // Scale limits
    localparam logic signed [15:0] DIFF_MIN = 16'hFC18;
    localparam logic signed [15:0] DIFF_MAX = 16'h03E8;
    localparam logic signed [15:0] WIDE_MIN = 16'hF2B8;
    localparam logic signed [15:0] WIDE_MAX = 16'h0D48;
    localparam logic signed [15:0] POS_MIN = 16'h0000;
    localparam logic signed [15:0] POS_MAX = 16'h1D4C;
    localparam logic signed [15:0] BIP_MIN = 16'hFC18;
    localparam logic signed [15:0] BIP_MAX = 16'h03E8;
    // Image sizes in bytes
    localparam int IMG_BYTES_1CH = 3;
    localparam int IMG_BYTES_2CH = 6;
    // Status and control bit positions
    localparam int SB_MODE = 7;
    localparam int SB_ERR = 6;
    localparam int SB_LIM2_LO = 4;
    localparam int SB_LIM1_LO = 2;
    localparam int SB_OVER = 1;
    localparam int SB_UNDER = 0;
    localparam int CB_MODE = 7;
    // Limit state codes
    localparam logic [1:0] LIM_OFF = 2'h0;
    localparam logic [1:0] LIM_ABOVE = 2'h1;
    localparam logic [1:0] LIM_BELOW = 2'h2;
    localparam logic [1:0] LIM_EQUAL = 2'h3;
    // APB register byte addresses
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_LIM1 = 8'h04;
    localparam logic [7:0] REG_LIM2 = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0C;
    localparam logic [7:0] REG_IRQ_STAT = 8'h10;
    localparam logic [7:0] REG_IRQ_MASK = 8'h14;
    localparam logic [7:0] REG_VALUE = 8'h18;
    // Control register fields
    localparam int CTRL_VAR_LO = 0;
    localparam int CTRL_LIM1_EN = 2;
    localparam int CTRL_LIM2_EN = 3;
    localparam int CTRL_TWO_CH = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // Interrupt event bits, two per channel
    localparam int EV_SAMPLE = 0;
    localparam int EV_RANGE = 1;
    localparam int EV_W = 4;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_ACCESS = 2'b10
    } ppf_apb_state_t;
endpackage : ppf_pkg

//--- rtl/ppf_chan_if.sv
// Interface carrying one channel's settings and image bytes
`timescale 1ns/10ps
interface ppf_chan_if;
    import ppf_pkg::*;
    logic [1:0] variant;
    logic lim1_en;
    logic lim2_en;
    logic signed [15:0] lim1;
    logic signed [15:0] lim2;
    logic [7:0] ctrl_octet;
    logic sample_valid;
    logic signed [15:0] sample;
    logic sample_err;
    logic [7:0] status_octet;
    logic [15:0] input_word;
    logic new_sample;
    logic range_event;
    modport top (output variant, lim1_en, lim2_en, lim1, lim2, ctrl_octet,
        sample_valid, sample, sample_err, input status_octet, input_word,
        new_sample, range_event);
    modport chan (input variant, lim1_en, lim2_en, lim1, lim2, ctrl_octet,
        sample_valid, sample, sample_err, output status_octet, input_word,
        new_sample, range_event);
endinterface : ppf_chan_if

//--- rtl/ppf_channel.sv
// One channel: status byte and pressure input word formation
`timescale 1ns/10ps
module ppf_channel
    import ppf_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    ppf_chan_if.chan ch
);
    logic [7:0] status_q, status_d;
    logic [15:0] word_q, word_d;
    logic new_q, new_d;
    logic range_q, range_d;
    logic signed [15:0] lo_lim, hi_lim;
    logic over, under;

    function automatic logic [1:0] lim_state(input logic en, input logic signed [15:0] v,
                                             input logic signed [15:0] t);
        if (!en) begin
            lim_state = LIM_OFF;
        end else if (v > t) begin
            lim_state = LIM_ABOVE;
        end else if (v < t) begin
            lim_state = LIM_BELOW;
        end else begin
            lim_state = LIM_EQUAL;
        end
    endfunction : lim_state

    always_comb begin
        case (ch.variant)
            VAR_DIFF: begin
                lo_lim = DIFF_MIN;
                hi_lim = DIFF_MAX;
            end
            VAR_DIFF_WIDE: begin
                lo_lim = WIDE_MIN;
                hi_lim = WIDE_MAX;
            end
            VAR_REL_POS: begin
                lo_lim = POS_MIN;
                hi_lim = POS_MAX;
            end
            default: begin
                lo_lim = BIP_MIN;
                hi_lim = BIP_MAX;
            end
        endcase
        over = ch.sample > hi_lim;
        under = ch.sample < lo_lim;
    end

    always_comb begin
        status_d = status_q;
        word_d = word_q;
        new_d = 1'b0;
        range_d = 1'b0;
        if (ch.ctrl_octet[CB_MODE]) begin
            status_d[SB_MODE] = 1'b1;
        end else begin
            status_d[SB_MODE] = 1'b0;
        end
        if (ch.sample_valid && !ch.ctrl_octet[CB_MODE]) begin
            word_d = ch.sample;
            status_d = 8'h00;
            status_d[SB_ERR] = ch.sample_err;
            status_d[SB_LIM2_LO +: 2] = lim_state(ch.lim2_en, ch.sample, ch.lim2);
            status_d[SB_LIM1_LO +: 2] = lim_state(ch.lim1_en, ch.sample, ch.lim1);
            status_d[SB_OVER] = over;
            status_d[SB_UNDER] = under;
            new_d = 1'b1;
            range_d = over | under | ch.sample_err;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_q <= 8'h00;
            word_q <= 16'h0000;
            new_q <= 1'b0;
            range_q <= 1'b0;
        end else begin
            status_q <= status_d;
            word_q <= word_d;
            new_q <= new_d;
            range_q <= range_d;
        end
    end

    assign ch.status_octet = status_q;
    assign ch.input_word = word_q;
    assign ch.new_sample = new_q;
    assign ch.range_event = range_q;
endmodule : ppf_channel

//--- tb/ppf_checker.sv
// Port assertions of the process image formatter
`timescale 1ns/10ps
module ppf_checker
    import ppf_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PREADY,
    input wire logic BUS_CYCLE_ACTIVE,
    input wire logic [47:0] OUTPUT_IMAGE,
    input wire logic [47:0] INPUT_IMAGE,
    input wire logic [2:0] IMAGE_BYTES,
    input wire logic [1:0] SAMPLE_VALID,
    input wire logic [31:0] SAMPLE_DATA,
    input wire logic [1:0] SAMPLE_ERR
);
    // ----------------------------------------
    // Image and ready properties
    // ----------------------------------------
    default clocking dcb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    property p_one_size;
        IMAGE_BYTES == 3'h3 && $past(IMAGE_BYTES) == 3'h3 |-> INPUT_IMAGE[47:24] == 24'h0;
    endproperty
    a_one_size: assert property (p_one_size) else $error("upper bytes used");
    property p_two_size;
        $past(RST_N) |-> IMAGE_BYTES inside {3'h3, 3'h6};
    endproperty
    a_two_size: assert property (p_two_size) else $error("bad image size");
    property p_word1;
        SAMPLE_VALID[0] && !OUTPUT_IMAGE[7] |=> INPUT_IMAGE[23:8] == $past(SAMPLE_DATA[15:0]);
    endproperty
    a_word1: assert property (p_word1) else $error("first word wrong");
    property p_word2;
        SAMPLE_VALID[1] && !OUTPUT_IMAGE[31] && IMAGE_BYTES == 3'h6
            |=> INPUT_IMAGE[47:32] == $past(SAMPLE_DATA[31:16]);
    endproperty
    a_word2: assert property (p_word2) else $error("second word wrong");
    property p_err;
        SAMPLE_VALID[0] && !OUTPUT_IMAGE[7] |=> INPUT_IMAGE[6] == $past(SAMPLE_ERR[0]);
    endproperty
    a_err: assert property (p_err) else $error("error flag wrong");
    property p_mode;
        $past(RST_N) |-> INPUT_IMAGE[7] == $past(OUTPUT_IMAGE[7]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode ack wrong");
    property p_hold;
        $past(RST_N) && !$past(SAMPLE_VALID[0]) |-> $stable(INPUT_IMAGE[23:8]);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed alone");
    property p_busy;
        BUS_CYCLE_ACTIVE |-> !PREADY;
    endproperty
    a_busy: assert property (p_busy) else $error("ready during exchange");
endmodule : ppf_checker

bind ppf_formatter ppf_checker #(.NUM_CH(NUM_CH)) i_chk (
    .CLK(CLK), .RST_N(RST_N), .PREADY(PREADY), .BUS_CYCLE_ACTIVE(BUS_CYCLE_ACTIVE),
    .OUTPUT_IMAGE(OUTPUT_IMAGE), .INPUT_IMAGE(INPUT_IMAGE), .IMAGE_BYTES(IMAGE_BYTES),
    .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_ERR(SAMPLE_ERR)
);

//--- tb/ppf_coupler_model.sv
// Coupler model exchanging the cyclic image with the formatter
`timescale 1ns/10ps
module ppf_coupler_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic busy,
    input wire logic [7:0] cb1,
    input wire logic [7:0] cb2,
    input wire logic [47:0] in_img,
    input wire logic [2:0] n_bytes,
    output logic cyc_act,
    output logic [47:0] out_img,
    output logic [47:0] seen
);
    // ----------------------------------------
    // Exchange
    // ----------------------------------------
    logic [15:0] junk;
    assign cyc_act = busy;
    assign out_img = {junk, cb2, ~junk, cb1};
    always_ff @(posedge clk) begin
        junk <= rst_n ? junk + 16'h3A5B : 16'hC3C3;
        seen <= (n_bytes == 3'h6) ? in_img : {24'h0, in_img[23:0]};
    end
endmodule : ppf_coupler_model

//--- tb/ppf_formatter_bench.sv
// Self-checking bench of the process image formatter
`timescale 1ns/10ps
module ppf_formatter_bench
    import ppf_pkg::*;
;
    // ----------------------------------------
    // Signals and tasks
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] v;
        logic [15:0] d;
        logic [1:0] ou;
    } ppf_row_t;
    ppf_row_t rows[12] = '{
        '{VAR_DIFF, 16'hFC18, 2'h0}, '{VAR_DIFF, 16'h03E8, 2'h0}, '{VAR_DIFF, 16'h03E9, 2'h2},
        '{VAR_DIFF, 16'hFC17, 2'h1}, '{VAR_DIFF_WIDE, 16'h0D48, 2'h0},
        '{VAR_DIFF_WIDE, 16'hF2B8, 2'h0}, '{VAR_DIFF_WIDE, 16'h0D49, 2'h2},
        '{VAR_REL_POS, 16'h1D4C, 2'h0}, '{VAR_REL_POS, 16'h1D4D, 2'h2},
        '{VAR_REL_POS, 16'hFFFF, 2'h1}, '{VAR_REL_BIP, 16'hFC18, 2'h0},
        '{VAR_REL_BIP, 16'h03E9, 2'h2}};
    logic [1:0] lim[3] = '{LIM_ABOVE, LIM_EQUAL, LIM_BELOW};
    logic CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, BUS_CYCLE_ACTIVE, busy, er;
    logic [7:0] PADDR, cb1, cb2;
    logic [31:0] PWDATA, PRDATA, SAMPLE_DATA, rd;
    logic [1:0] SAMPLE_VALID, SAMPLE_ERR;
    logic [47:0] OUTPUT_IMAGE, INPUT_IMAGE, seen;
    logic [2:0] IMAGE_BYTES;
    int err_total, n_compared, waits, i;
    ppf_formatter #(.NUM_CH(2)) i_dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .BUS_CYCLE_ACTIVE(BUS_CYCLE_ACTIVE), .OUTPUT_IMAGE(OUTPUT_IMAGE),
        .INPUT_IMAGE(INPUT_IMAGE), .IMAGE_BYTES(IMAGE_BYTES), .SAMPLE_VALID(SAMPLE_VALID),
        .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_ERR(SAMPLE_ERR), .IRQ(IRQ));
    ppf_coupler_model i_cpl (.clk(CLK), .rst_n(RST_N), .busy(busy), .cb1(cb1), .cb2(cb2),
        .in_img(INPUT_IMAGE), .n_bytes(IMAGE_BYTES), .cyc_act(BUS_CYCLE_ACTIVE),
        .out_img(OUTPUT_IMAGE), .seen(seen));
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    task automatic test_done;
        $display("mismatches %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        // Ready and answer are taken at the rising edge itself
        for (waits = 0; waits < 40; waits++) begin
            @(posedge CLK);
            if (PREADY === 1'b1) break;
        end
        if (waits == 40) begin
            err_total++;
            test_done();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic smp(input logic [1:0] v, input logic [31:0] d, input logic [1:0] e);
        @(posedge CLK);
        SAMPLE_VALID <= v;
        SAMPLE_DATA <= d;
        SAMPLE_ERR <= e;
        @(posedge CLK);
        SAMPLE_VALID <= 2'h0;
        repeat (2) @(posedge CLK);
        #1;
    endtask : smp
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        {RST_N, PSEL, PENABLE, PWRITE, busy, PADDR, cb1, cb2} = '0;
        {PWDATA, SAMPLE_DATA, SAMPLE_VALID, SAMPLE_ERR, err_total, n_compared} = '0;
        repeat (20) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        #1;
        chk({PREADY, IRQ, IMAGE_BYTES, INPUT_IMAGE[42:0]}, {2'h0, 3'h3, 43'h0});
        apb(1'b0, REG_CTRL, ZERO32);
        chk({16'h0, rd}, {16'h0, CTRL_RST});
        foreach (rows[k]) begin
            apb(1'b1, REG_CTRL, {30'h0, rows[k].v});
            smp(2'h1, {16'h0, rows[k].d}, 2'h0);
            chk(seen, {24'h0, rows[k].d, 6'h0, rows[k].ou});
        end
        @(posedge CLK);
        cb1 <= 8'h80;
        smp(2'h1, 32'h0000_1234, 2'h0);
        chk(48'(seen[23:7]), {31'h0, 16'h03E9, 1'b1});
        @(posedge CLK);
        cb1 <= 8'h00;
        apb(1'b1, REG_CTRL, 32'h0000_0010);
        smp(2'h3, 32'h0064_FF9C, 2'h1);
        chk(seen, 48'h0064_00FF_9C40);
        chk(48'(IMAGE_BYTES), 48'h6);
        apb(1'b1, REG_CTRL, 32'h0000_0004);
        apb(1'b1, REG_LIM1, 32'h0000_0010);
        for (i = 0; i < 3; i++) begin
            smp(2'h1, 32'h0000_0011 - i, 2'h0);
            chk(seen, {24'h0, 16'h0011 - 16'(i), 4'h0, lim[i], 2'h0});
        end
        chk(48'(IRQ), 48'h0);
        apb(1'b1, REG_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge CLK);
        #1;
        chk(48'(IRQ), 48'h1);
        apb(1'b0, REG_IRQ_STAT, ZERO32);
        chk(48'(rd), 48'h7);
        repeat (2) @(posedge CLK);
        #1;
        chk(48'(IRQ), 48'h0);
        smp(2'h1, 32'h0000_0005, 2'h0);
        @(posedge CLK);
        #1;
        chk(48'(IRQ), 48'h1);
        fork
            apb(1'b0, REG_CTRL, ZERO32);
            begin
                @(posedge CLK);
                busy <= 1'b1;
                repeat (4) @(posedge CLK);
                busy <= 1'b0;
            end
        join
        chk({rd, 16'(waits)}, {32'h0000_0004, 16'h3});
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        chk(48'(er), 48'h1);
        apb(1'b0, 8'h1C, ZERO32);
        chk({15'h0, er, rd}, {15'h0, 1'b1, 32'h0});
        RST_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        #1;
        chk({PREADY, IRQ, IMAGE_BYTES, INPUT_IMAGE[42:0]}, {2'h0, 3'h3, 43'h0});
        apb(1'b0, REG_CTRL, ZERO32);
        chk({16'h0, rd}, {16'h0, CTRL_RST});
        test_done();
    end
endmodule : ppf_formatter_bench
